// ### verilog/reset_mode_pkg.sv
// Shared constants, states and bus carriers for the reset and mode block.
package reset_mode_pkg;

  // Register port geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PSIZE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SEQ = 4'hC;

  // Control register bit positions.
  localparam int CTRL_RE_BIT = 0;
  localparam int CTRL_DREFILL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Port width codes held per memory sub-region.
  localparam int PSIZE_W = 2;
  localparam logic [PSIZE_W-1:0] PSIZE_32 = 2'h0;
  localparam logic [PSIZE_W-1:0] PSIZE_8 = 2'h1;
  localparam logic [PSIZE_W-1:0] PSIZE_16 = 2'h2;

  // Boot and fetch constants.
  localparam logic [31:0] RESET_VECTOR = 32'h1FC0_0000;
  localparam logic [2:0] VECTOR_EDGES = 3'h6;
  localparam int SYNC_STAGES = 2;
  localparam logic [2:0] IREFILL_WORDS = 3'h4;
  localparam logic [2:0] DREFILL_LONG = 3'h4;
  localparam logic [2:0] DREFILL_SHORT = 3'h1;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_FLUSH = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_t;

  // Captured configuration; strap levels as seen on the pins.
  typedef struct packed {
    logic endian_select_strap;
    logic diag_trace_strap;
    logic extended_hold_strap;
    logic boot_width8_strap;
    logic boot_width16_strap;
    logic [2:0] test_reserved_strap;
  } mode_t;
  localparam mode_t MODE_DEFAULT = 8'hFF;

  // Bus intent from the execution core, strobes active low except ALE.
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic data_en_n;
    logic burst_n;
    logic mem_strobe_n;
    logic last_n;
    logic tc_n;
    logic grant_n;
    logic diag;
    logic addr_valid;
    logic idle;
    logic ext_data_enable_n;
    logic io_strobe_a_n;
    logic [31:0] ad;
    logic [3:0] addr_lo;
    logic [1:0] be;
  } core_bus_t;

  // Pin-level bus; every oe_n is low while the pin is driven.
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic data_enable_out;
    logic burst_indicator;
    logic memory_strobe;
    logic last_n;
    logic terminal_count;
    logic bus_grant_out;
    logic diag;
    logic [31:0] ad_out;
    logic ad_oe_n;
    logic [3:0] addr_lo_out;
    logic addr_lo_oe_n;
    logic [1:0] be_out;
    logic be_oe_n;
    logic ext_data_enable;
    logic io_strobe_a;
    logic branch_oe_n;
  } pin_bus_t;

endpackage

// ### verilog/reset_sync.sv
// Reset synchroniser: asserts at once, releases after a chain of flops.
`timescale 1ns/10ps
module reset_sync #(
  parameter int STAGES = 2 // Number of release delay flops.
) (
  input wire logic clock, // Input clock.
  input wire logic rst, // External reset, asynchronous, active high.
  output logic core_rst // Reset seen by the core, active high.
);

  // Fewer than two stages would not settle a metastable release.
  initial begin
    if (STAGES < 2) begin
      $error("reset_sync needs at least two stages.");
    end
  end

  logic [STAGES-1:0] chain_ff; // Release shift chain.

  // Assertion is immediate; negation walks through the chain.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chain_ff <= '1;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], 1'b0};
    end
  end

  // Only the last stage is visible outside.
  assign core_rst = chain_ff[STAGES-1];

endmodule

// ### verilog/reset_mode_seq.sv
// Reset mode capture, reset pin states and boot fetch sequencing.
`timescale 1ns/10ps

// Overview of operation
// - Capture mode straps when reset negates.
// - Straps map to endian, diag, hold, boot.
// - Pulled-up straps default high when open.
// - Endian strap plus reverse bit sets endianness.
// - Diag low shows cache address when idle.
// - Diag low forces every cacheable access external.
// - Hold low extends address, delays data enable.
// - Boot8 low resets port map to 8-bit if Boot16 is high.
// - Boot16 low resets port map to 16-bit.
// - Fixed instruction refill size and always-on features.
// - Bus clock runs at half input rate.
// - Reset floats bus pins, holds ALE low.
// - Reset drives control strobes high, diag defined.
// - Vector read at sixth rising bus edge.
// - Synchroniser delays reset negation two cycles.
// - Boot from uncached unmapped reset vector.
// - Latch transparent during reset, frozen at release.
module reset_mode_seq
  import reset_mode_pkg::*;
#(
  parameter int REGIONS = 8 // Memory sub-regions in the port map.
) (
  input wire logic clock, // Input clock, 20 MHz.
  input wire logic rst, // External reset, asynchronous, active high.
  input wire logic [reset_mode_pkg::ADDR_W-1:0] reg_addr, // Byte address.
  input wire logic [reset_mode_pkg::DATA_W-1:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [reset_mode_pkg::DATA_W-1:0] reg_rdata, // Read data.
  input wire logic sync_irq_in, // Endian strap pin.
  input wire logic irq3_in, // Diagnostic strap pin.
  input wire logic [3:0] addr_lo_in, // Low address pins, read side.
  input wire logic [1:0] half_byte_enables, // Byte-enable pins, read side.
  input wire logic float_all_in, // Low floats the AD, low address, byte-enable and branch pins.
  input wire reset_mode_pkg::core_bus_t core_bus, // Core bus intent.
  input wire logic [31:0] cache_trace_addr, // Latched cache address.
  output reset_mode_pkg::pin_bus_t pins, // Pin drive and enables.
  output logic bus_clock_out, // Bus clock, half the input rate.
  output logic core_rst_out, // Reset to the execution core.
  output logic fetch_start, // Pulse: read of the reset vector.
  output logic [31:0] fetch_addr, // Address of that read.
  output logic fetch_uncached, // Vector space is uncached.
  output reset_mode_pkg::mode_t mode_out, // Captured strap values.
  output logic force_cache_miss, // Treat every cache access as miss.
  output logic big_endian_core, // Machine endianness.
  output logic task_big_endian, // Endianness for the running task.
  output logic [REGIONS*reset_mode_pkg::PSIZE_W-1:0] port_size_map, // Map.
  output logic [2:0] icache_refill_words, // Instruction refill words.
  output logic [2:0] dcache_refill_words, // Data refill words.
  output logic features_on // Reverse endian, streaming, partial stores.
);

  // Port map must fit in one register word.
  initial begin
    if (REGIONS < 1 || REGIONS * PSIZE_W > DATA_W) begin
      $error("reset_mode_seq: REGIONS out of range.");
    end
  end

  localparam int MAP_W = REGIONS * PSIZE_W;

  // Fill the whole port map with one width code.
  function automatic logic [MAP_W-1:0] fill_map(input logic [PSIZE_W-1:0] c);
    logic [MAP_W-1:0] m;
    m = '0;
    for (int i = 0; i < REGIONS; i++) begin
      m[i*PSIZE_W +: PSIZE_W] = c;
    end
    return m;
  endfunction

  // Synchronised reset that the core and sequencer follow.
  logic core_rst;

  reset_sync #(
    .STAGES(SYNC_STAGES)
  ) u_reset_sync (
    .clock(clock),
    .rst(rst),
    .core_rst(core_rst)
  );

  // The core sees the last synchroniser flop itself; one more register
  // here would stretch the release to three cycles.
  assign core_rst_out = core_rst;

  // Strap pins come from the board, so each passes two flops first.
  // These flops carry no reset; they must already hold pin levels
  // when the synchronised reset releases, or defaults would be caught.
  logic [7:0] strap_meta_ff; // First stage, read only by the second.
  logic [7:0] strap_sync_ff; // Second stage.
  logic float_meta_ff; // First stage of the float input.
  logic float_sync_ff; // Second stage of the float input.
  wire [7:0] strap_pins = {sync_irq_in, irq3_in, addr_lo_in[0],
                           addr_lo_in[2], addr_lo_in[3], addr_lo_in[1],
                           half_byte_enables};

  always_ff @(posedge clock) begin
    strap_meta_ff <= strap_pins;
    strap_sync_ff <= strap_meta_ff;
    float_meta_ff <= float_all_in;
    float_sync_ff <= float_meta_ff;
  end

  // Mode latch: follows the straps while reset holds, then freezes.
  // Defaults are high so pulled-up pins left open read inactive.
  mode_t mode_ff; // Captured configuration.
  wire mode_t nxt_mode = core_rst ? mode_t'(strap_sync_ff) : mode_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff <= MODE_DEFAULT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Port map reset value from the boot straps; 16-bit wins if both low.
  wire [PSIZE_W-1:0] boot_code =
    !mode_ff.boot_width16_strap ? PSIZE_16 :
    !mode_ff.boot_width8_strap ? PSIZE_8 : PSIZE_32;

  // Register write decode.
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_psize = reg_wr && (reg_addr == REG_PSIZE);

  // Control register: reverse endian and data refill size.
  logic [1:0] ctrl_ff;
  wire [1:0] nxt_ctrl = wr_ctrl ? reg_wdata[1:0] : ctrl_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Port map reloads from the straps while reset holds.
  logic [MAP_W-1:0] psize_ff;
  wire [MAP_W-1:0] nxt_psize = core_rst ? fill_map(boot_code) :
                               wr_psize ? reg_wdata[MAP_W-1:0] : psize_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      psize_ff <= fill_map(PSIZE_32);
    end else begin
      psize_ff <= nxt_psize;
    end
  end

  // Bus clock toggles on every rising input edge, reset or not; a reset here
  // would stop the clock that the board needs while reset is held.
  logic bus_clk_ff = 1'b0; // Starts low, then runs free.

  always_ff @(posedge clock) begin
    bus_clk_ff <= ~bus_clk_ff;
    bus_clock_out <= bus_clk_ff;
  end

  // A bus rising edge follows a cycle with the bus clock low.
  wire bus_rise_next = !bus_clk_ff;
  wire bus_fall_next = bus_clk_ff;

  // Boot sequencer: detect release on a falling bus edge, then count
  // rising bus edges for flush and propagation before the vector read.
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [2:0] edge_cnt_ff;
  logic [2:0] nxt_edge_cnt;
  wire last_edge = (edge_cnt_ff == VECTOR_EDGES - 3'h1);

  always_comb begin
    nxt_state = state_ff;
    nxt_edge_cnt = edge_cnt_ff;
    case (state_ff)
      ST_RESET: begin
        if (!core_rst && bus_fall_next) begin
          nxt_state = ST_FLUSH;
          nxt_edge_cnt = 3'h0;
        end
      end
      ST_FLUSH: begin
        if (bus_rise_next) begin
          nxt_edge_cnt = edge_cnt_ff + 3'h1;
          if (last_edge) begin
            nxt_state = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
    if (core_rst) begin
      nxt_state = ST_RESET;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RESET;
      edge_cnt_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      edge_cnt_ff <= nxt_edge_cnt;
    end
  end

  // Bus pins are quiet until the vector read is issued.
  wire in_reset = (state_ff == ST_RESET) || (state_ff == ST_FLUSH);
  wire diag_on = !mode_ff.diag_trace_strap;
  wire hold_on = !mode_ff.extended_hold_strap;

  // Extended hold keeps the address one more input cycle, which is
  // half a bus clock, and delays data enable by the same amount.
  logic ale_d_ff;
  logic hold_ext_ff;
  logic data_en_d_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ale_d_ff <= 1'b0;
      hold_ext_ff <= 1'b0;
      data_en_d_ff <= 1'b1;
    end else begin
      ale_d_ff <= core_bus.ale;
      hold_ext_ff <= hold_on && ale_d_ff && !core_bus.ale;
      data_en_d_ff <= core_bus.data_en_n;
    end
  end

  // Idle trace display drives the cache address with ALE left low.
  wire trace_cycle = diag_on && core_bus.idle;
  wire addr_drive = core_bus.addr_valid || hold_ext_ff;
  wire data_en_sel = hold_on ? data_en_d_ff : core_bus.data_en_n;

  // Pin values in normal operation.
  pin_bus_t run_pins;
  pin_bus_t nxt_pins;

  always_comb begin
    run_pins.ale = trace_cycle ? 1'b0 : core_bus.ale;
    run_pins.rd_n = core_bus.rd_n;
    run_pins.wr_n = core_bus.wr_n;
    run_pins.data_enable_out = data_en_sel;
    run_pins.burst_indicator = core_bus.burst_n;
    run_pins.memory_strobe = core_bus.mem_strobe_n;
    run_pins.last_n = core_bus.last_n;
    run_pins.terminal_count = core_bus.tc_n;
    run_pins.bus_grant_out = core_bus.grant_n;
    run_pins.diag = core_bus.diag;
    run_pins.ad_out = trace_cycle ? cache_trace_addr : core_bus.ad;
    run_pins.ad_oe_n = !(addr_drive || trace_cycle);
    run_pins.addr_lo_out = core_bus.addr_lo;
    run_pins.addr_lo_oe_n = !addr_drive;
    run_pins.be_out = core_bus.be;
    run_pins.be_oe_n = !addr_drive;
    run_pins.ext_data_enable = core_bus.ext_data_enable_n;
    run_pins.io_strobe_a = core_bus.io_strobe_a_n;
    run_pins.branch_oe_n = 1'b0;
  end

  // Reset pin states; the diag pin is driven low as its defined value.
  pin_bus_t rst_pins;

  always_comb begin
    rst_pins = '0;
    rst_pins.ad_oe_n = 1'b1;
    rst_pins.addr_lo_oe_n = 1'b1;
    rst_pins.be_oe_n = 1'b1;
    rst_pins.branch_oe_n = 1'b1;
    rst_pins.ale = 1'b0;
    rst_pins.data_enable_out = 1'b1;
    rst_pins.burst_indicator = 1'b1;
    rst_pins.bus_grant_out = 1'b1;
    rst_pins.rd_n = 1'b1;
    rst_pins.wr_n = 1'b1;
    rst_pins.memory_strobe = 1'b1;
    rst_pins.last_n = 1'b1;
    rst_pins.terminal_count = 1'b1;
    rst_pins.diag = 1'b0;
    rst_pins.ext_data_enable = 1'b1;
    rst_pins.io_strobe_a = 1'b1;
  end

  // Float request overrides every enable; shared strap pins stay
  // undriven through reset so the board straps can be read.
  always_comb begin
    nxt_pins = in_reset ? rst_pins : run_pins;
    if (!float_sync_ff) begin
      nxt_pins.ad_oe_n = 1'b1;
      nxt_pins.addr_lo_oe_n = 1'b1;
      nxt_pins.be_oe_n = 1'b1;
      nxt_pins.branch_oe_n = 1'b1;
    end
  end

  // Registered pins and side outputs.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins <= '0;
      pins.ad_oe_n <= 1'b1;
      pins.addr_lo_oe_n <= 1'b1;
      pins.be_oe_n <= 1'b1;
      pins.branch_oe_n <= 1'b1;
      pins.data_enable_out <= 1'b1;
      pins.burst_indicator <= 1'b1;
      pins.bus_grant_out <= 1'b1;
      pins.rd_n <= 1'b1;
      pins.wr_n <= 1'b1;
      pins.memory_strobe <= 1'b1;
      pins.last_n <= 1'b1;
      pins.terminal_count <= 1'b1;
      pins.ext_data_enable <= 1'b1;
      pins.io_strobe_a <= 1'b1;
    end else begin
      pins <= nxt_pins;
    end
  end

  // Fetch request and configuration outputs, all registered.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_start <= 1'b0;
      fetch_addr <= RESET_VECTOR;
      fetch_uncached <= 1'b1;
      mode_out <= MODE_DEFAULT;
      force_cache_miss <= 1'b0;
      big_endian_core <= 1'b1;
      task_big_endian <= 1'b1;
      port_size_map <= fill_map(PSIZE_32);
      icache_refill_words <= IREFILL_WORDS;
      dcache_refill_words <= DREFILL_SHORT;
      features_on <= 1'b1;
    end else begin
      fetch_start <= (nxt_state == ST_FETCH);
      fetch_addr <= RESET_VECTOR;
      fetch_uncached <= 1'b1;
      mode_out <= mode_ff;
      force_cache_miss <= diag_on;
      big_endian_core <= mode_ff.endian_select_strap;
      task_big_endian <= mode_ff.endian_select_strap ^
                         ctrl_ff[CTRL_RE_BIT];
      port_size_map <= psize_ff;
      icache_refill_words <= IREFILL_WORDS;
      dcache_refill_words <= ctrl_ff[CTRL_DREFILL_BIT] ?
                             DREFILL_LONG : DREFILL_SHORT;
      features_on <= 1'b1;
    end
  end

  // Read selection; unmapped offsets read zero.
  logic [DATA_W-1:0] rd_sel;

  always_comb begin
    rd_sel = '0;
    if (reg_addr == REG_CTRL) begin
      rd_sel[1:0] = ctrl_ff;
    end else if (reg_addr == REG_MODE) begin
      rd_sel[7:0] = mode_ff;
    end else if (reg_addr == REG_PSIZE) begin
      rd_sel[MAP_W-1:0] = psize_ff;
    end else if (reg_addr == REG_SEQ) begin
      rd_sel[3:0] = state_ff;
      rd_sel[6:4] = edge_cnt_ff;
    end
  end

  // Read data stand for the one cycle after the strobe only.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_sel : '0;
    end
  end

endmodule

// ### test/reset_mode_seq_checker.sv
// Port assertions for the reset mode capture and boot sequencer.
`timescale 1ns/10ps
module reset_mode_seq_checker
  import reset_mode_pkg::*;
(
  input wire logic clock, // Input clock.
  input wire logic rst, // External reset.
  input wire reset_mode_pkg::pin_bus_t pins, // Pin drive.
  input wire logic bus_clock_out, // Half-rate clock.
  input wire logic core_rst_out, // Core reset.
  input wire logic fetch_start, // Vector read pulse.
  input wire logic [31:0] fetch_addr, // Vector address.
  input wire logic fetch_uncached, // Vector space flag.
  input wire reset_mode_pkg::mode_t mode_out, // Captured straps.
  input wire logic force_cache_miss, // Forced miss.
  input wire logic big_endian_core, // Machine endianness.
  input wire logic [2:0] icache_refill_words, // Instruction refill.
  input wire logic features_on // Always-on features.
);
  default clocking cb @(posedge clock);
  endclocking
  logic [1:0] armed_ff = 2'b00; // Keeps $past off the first two edges.
  // Helper shift, full once two edges have passed.
  always @(posedge clock) begin
    armed_ff <= {armed_ff[0], 1'b1};
  end
  property p_reset_float;
    rst |-> pins.ad_oe_n && pins.addr_lo_oe_n && pins.be_oe_n
      && pins.branch_oe_n && !pins.ale;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("bus pins not floated in reset");
  property p_reset_drive;
    rst |-> pins.data_enable_out && pins.burst_indicator && pins.rd_n
      && pins.wr_n && pins.bus_grant_out && pins.memory_strobe
      && pins.last_n && pins.terminal_count;
  endproperty
  a_reset_drive: assert property (p_reset_drive)
    else $error("control strobes not high in reset");
  property p_half_rate;
    armed_ff[1] && rst && $past(rst)
      |-> bus_clock_out != $past(bus_clock_out);
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("bus clock not at half rate in reset");
  property p_sync_release;
    disable iff (rst) $fell(rst) |-> core_rst_out ##1 core_rst_out
      ##1 !core_rst_out;
  endproperty
  a_sync_release: assert property (p_sync_release)
    else $error("core reset release not two cycles late");
  // The vector read waits six bus rising edges after detection.
  property p_vector_timing;
    disable iff (rst) $fell(core_rst_out) |-> (!fetch_start)[*8]
      ##[5:6] fetch_start;
  endproperty
  a_vector_timing: assert property (p_vector_timing)
    else $error("vector read at wrong time");
  property p_vector_pulse;
    disable iff (rst) fetch_start |=> !fetch_start;
  endproperty
  a_vector_pulse: assert property (p_vector_pulse)
    else $error("vector read pulse too long");
  property p_fetch_vector;
    disable iff (rst) fetch_start |-> fetch_addr == 32'h1FC0_0000
      && fetch_uncached;
  endproperty
  a_fetch_vector: assert property (p_fetch_vector)
    else $error("vector read address wrong");
  property p_mode_hold;
    disable iff (rst) !core_rst_out && $past(!core_rst_out)
      |-> $stable(mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("captured modes changed while running");
  property p_force_miss;
    disable iff (rst) (!core_rst_out)[*3]
      |-> force_cache_miss == !mode_out.diag_trace_strap;
  endproperty
  a_force_miss: assert property (p_force_miss)
    else $error("forced miss does not follow strap");
  property p_endian;
    disable iff (rst) (!core_rst_out)[*3]
      |-> big_endian_core == mode_out.endian_select_strap;
  endproperty
  a_endian: assert property (p_endian)
    else $error("endianness does not follow strap");
  property p_refill_fixed;
    disable iff (rst) icache_refill_words == 3'h4 && features_on;
  endproperty
  a_refill_fixed: assert property (p_refill_fixed)
    else $error("fixed refill or features wrong");
endmodule

// ### test/strap_board.sv
// Board model: strap resistors, interrupt sources and reset source.
`timescale 1ns/10ps
module strap_board
  import reset_mode_pkg::*;
#(
  parameter int RST_CYCLES = 8, // Reset length, warm and cold alike.
  parameter int HOLD = 4 // Quiet cycles after release.
) (
  input wire logic clock, // Input clock.
  input wire logic start, // Pulse: begin a warm reset.
  input wire reset_mode_pkg::mode_t cfg, // Strap resistor levels.
  input wire reset_mode_pkg::pin_bus_t pins, // Device pin drive.
  output logic rst, // Reset to the device.
  output logic sync_irq_in, // Endian strap and interrupt line.
  output logic irq3_in, // Diagnostic strap and interrupt line.
  output logic [3:0] addr_lo_in, // Resolved low address lines.
  output logic [1:0] half_byte_enables, // Resolved byte enables.
  output logic float_all_in // Float control, left open.
);
  int cnt = RST_CYCLES + HOLD; // Cycles left until traffic starts.
  logic tog = 1'b0; // Interrupt activity, changes every cycle.
  initial rst = 1'b1;
  // One length for every reset: weak pull-ups need the full time.
  always @(posedge clock) begin
    cnt <= start ? RST_CYCLES + HOLD : (cnt > 0 ? cnt - 1 : 0);
    rst <= start || cnt > HOLD;
    tog <= ~tog;
  end
  // Interrupt sources wait until the straps are surely taken.
  assign sync_irq_in = cnt == 0 ? tog : cfg.endian_select_strap;
  assign irq3_in = cnt == 0 ? ~tog : cfg.diag_trace_strap;
  // A released line falls back to its resistor; test lines sit high.
  assign addr_lo_in = pins.addr_lo_oe_n ? {cfg.boot_width16_strap,
    cfg.boot_width8_strap, 1'b1, cfg.extended_hold_strap}
    : pins.addr_lo_out;
  assign half_byte_enables = pins.be_oe_n ? 2'b11 : pins.be_out;
  assign float_all_in = 1'b1;
endmodule

// ### test/tb_top.sv
// Self-checking bench for the reset mode capture and boot sequencer.
`timescale 1ns/10ps
module tb_top;
  import reset_mode_pkg::*;
  logic clock = 1'b0; // 20 MHz clock.
  logic start = 1'b0; // Warm reset request to the board.
  logic rst; // Reset from the board.
  logic [3:0] reg_addr = 4'h0; // Register address.
  logic [31:0] reg_wdata = 32'h0000_0000; // Write data.
  logic reg_wr = 1'b0; // Write strobe.
  logic reg_rd = 1'b0; // Read strobe.
  logic [31:0] reg_rdata, fetch_addr, rd_val; // Read data and vector.
  logic sync_irq_in, irq3_in, float_all_in; // Strap lines.
  logic [3:0] addr_lo_in; // Low address lines.
  logic [1:0] half_byte_enables; // Byte-enable lines.
  core_bus_t core_bus = '0; // Random core intent.
  logic [63:0] raw; // Random source for the core intent.
  logic [31:0] trace_addr = 32'h0000_0000; // Random trace address.
  mode_t cfg = MODE_DEFAULT; // Open pins read high.
  pin_bus_t pins; // Device pin drive.
  logic bus_clock_out, core_rst_out, fetch_start, fetch_uncached;
  logic force_cache_miss, big_endian_core, task_big_endian, features_on;
  mode_t mode_out; // Captured straps.
  logic [15:0] port_size_map; // Port width map.
  logic [2:0] icache_refill_words, dcache_refill_words; // Refills.
  logic [31:0] seed = 32'h0000_653f; // Fixed xorshift start.
  int miscompares = 0; // Mismatches.
  int check_count = 0; // Comparisons.

  always #25 clock = ~clock;

  reset_mode_seq u_reset_mode_seq (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_irq_in(sync_irq_in),
    .irq3_in(irq3_in), .addr_lo_in(addr_lo_in),
    .half_byte_enables(half_byte_enables), .float_all_in(float_all_in),
    .core_bus(core_bus), .cache_trace_addr(trace_addr), .pins(pins),
    .bus_clock_out(bus_clock_out), .core_rst_out(core_rst_out),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .fetch_uncached(fetch_uncached), .mode_out(mode_out),
    .force_cache_miss(force_cache_miss), .big_endian_core(big_endian_core),
    .task_big_endian(task_big_endian), .port_size_map(port_size_map),
    .icache_refill_words(icache_refill_words),
    .dcache_refill_words(dcache_refill_words), .features_on(features_on));

  strap_board u_strap_board (.clock(clock), .start(start), .cfg(cfg),
    .pins(pins), .rst(rst), .sync_irq_in(sync_irq_in), .irq3_in(irq3_in),
    .addr_lo_in(addr_lo_in), .half_byte_enables(half_byte_enables),
    .float_all_in(float_all_in));

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected map: the 16-bit boot strap wins when both are low.
  function automatic logic [15:0] exp_map(input mode_t m);
    logic [1:0] code;
    code = !m.boot_width16_strap ? PSIZE_16 :
      (!m.boot_width8_strap ? PSIZE_8 : PSIZE_32);
    return {8{code}};
  endfunction

  // Random core traffic; it must never disturb the captured modes.
  always @(posedge clock) begin
    raw = {next_rand(), next_rand()};
    core_bus <= raw[$bits(core_bus_t)-1:0];
    trace_addr <= next_rand();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
  endtask

  // Bounded wait for the vector read pulse.
  task automatic wait_boot();
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < 80) begin
      @(negedge clock);
      n++;
    end
    if (fetch_start !== 1'b1) begin
      miscompares++;
      test_done();
    end else begin
      check(fetch_addr, 32'h1FC0_0000);
      check(fetch_uncached, 1'b1);
    end
  endtask

  task automatic run_checks(input int i);
    logic [1:0] c;
    c = next_rand() & 32'h0000_0003;
    check(mode_out, cfg);
    check(force_cache_miss, !cfg.diag_trace_strap);
    check(big_endian_core, cfg.endian_select_strap);
    check(port_size_map, exp_map(cfg));
    check(icache_refill_words, 3'h4);
    check(features_on, 1'b1);
    reg_read(REG_MODE);
    check(rd_val, {24'h00_0000, cfg});
    reg_write(REG_MODE, 32'h0000_0000);
    reg_read(REG_MODE);
    check(rd_val, {24'h00_0000, cfg});
    reg_read(REG_PSIZE);
    check(rd_val, {16'h0000, exp_map(cfg)});
    reg_write(REG_CTRL, {30'h0000_0000, c});
    reg_read(REG_CTRL);
    check(rd_val, {30'h0000_0000, c});
    check(task_big_endian, cfg.endian_select_strap ^ c[0]);
    check(dcache_refill_words, c[1] ? 3'h4 : 3'h1);
    reg_read(4'h2);
    check(rd_val, 32'h0000_0000);
    $display("test %0d done", i);
  endtask

  // Cold start first, then warm resets; the first three warm ones pin
  // down both boot straps low, 8-bit only and 16-bit only.
  initial begin
    int i;
    mode_t m;
    for (i = 0; i < 8; i++) begin
      if (i > 0) begin
        m = mode_t'({next_rand() & 32'h0000_00f8} | 8'h07);
        if (i < 4) {m.boot_width8_strap, m.boot_width16_strap} = 2'(i - 1);
        @(posedge clock);
        cfg <= m;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
      end
      wait_boot();
      run_checks(i);
    end
    test_done();
  end
endmodule

bind reset_mode_seq reset_mode_seq_checker u_reset_mode_seq_checker (
  .clock(clock), .rst(rst), .pins(pins), .bus_clock_out(bus_clock_out),
  .core_rst_out(core_rst_out), .fetch_start(fetch_start),
  .fetch_addr(fetch_addr), .fetch_uncached(fetch_uncached),
  .mode_out(mode_out), .force_cache_miss(force_cache_miss),
  .big_endian_core(big_endian_core),
  .icache_refill_words(icache_refill_words), .features_on(features_on));
